// ===== apmux_consts.svh
`ifndef APMUX_CONSTS_SVH
`define APMUX_CONSTS_SVH

// ==========================================================
// pin counts
`define APMUX_LOW_W 16
`define APMUX_UPPER_W 8
`define APMUX_UPPER_BASE 16

// ==========================================================
// upper pin positions, counted from the first upper address pin
`define APMUX_IDX_RX 2
`define APMUX_IDX_TX 3
`define APMUX_IDX_CLK 4
`define APMUX_IDX_CAP_A 5
`define APMUX_IDX_CAP_B 6
`define APMUX_IDX_CAP_C 7

// ==========================================================
// reset values and the select code for address
`define APMUX_RST_OUT 8'h00
`define APMUX_RST_OE 8'h00
`define APMUX_SEL_ADDR 1'b1

`endif

// ===== apmux_pin_mux.sv
`timescale 1ns/1ns
`include "apmux_consts.svh"

// Summary of operation
// - address bits 0 to 15 always drive their pins as address outputs
// - upper pin drives its address bit when its select bit chooses address
// - upper pin is a port bit when its select bit chooses port
// - serial 0 transmit data takes pin 19 while its output is enabled
// - address or port on pin 19 only with transmit output disabled
// - port on pin 20 needs both clocks off; address needs serial 0 clock off
// - serial 0 clock output overrides port and address on pin 20
// - simple serial data output takes pin 21 while enabled
// - capture inputs a, b, c come from pins 21, 22, 23 always
// - timer inputs a, b come from pins 21 and 22
// - serial 0 receive data comes from pin 18
module apmux_pin_mux (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [23:0] addr_in,
  input wire logic [`APMUX_UPPER_W-1:0] upper_sel,
  input wire logic [`APMUX_UPPER_W-1:0] port4_data,
  input wire logic [`APMUX_UPPER_W-1:0] port4_dir,
  input wire apmux_pkg::apmux_alt_t alt_in,
  output logic [`APMUX_LOW_W-1:0] low_addr_pins,
  input wire logic [`APMUX_UPPER_W-1:0] upper_pin_in,
  output logic [`APMUX_UPPER_W-1:0] upper_pin_out,
  output logic [`APMUX_UPPER_W-1:0] upper_pin_oe,
  output logic [`APMUX_UPPER_W-1:0] port4_read,
  output apmux_pkg::apmux_periph_t periph_out
);

  typedef struct packed {
    logic [`APMUX_LOW_W-1:0] low_addr;
    logic [`APMUX_UPPER_W-1:0] pin_out;
    logic [`APMUX_UPPER_W-1:0] pin_oe;
    apmux_pkg::apmux_func_t [`APMUX_UPPER_W-1:0] func;
  } apmux_state_t;

  apmux_state_t state_reg;
  apmux_state_t state_next;
  logic [`APMUX_UPPER_W-1:0] pin_sync;

  // ==========================================================
  // function selection per upper pin
  function automatic apmux_pkg::apmux_func_t pick_func(
    input int unsigned idx,
    input logic sel_addr,
    input apmux_pkg::apmux_alt_t alt
  );
    apmux_pkg::apmux_func_t f;
    f = sel_addr ? apmux_pkg::APMUX_FN_ADDR : apmux_pkg::APMUX_FN_PORT;
    if (idx == `APMUX_IDX_TX && alt.serial0_tx_en) begin
      f = apmux_pkg::APMUX_FN_S0_TX;
    end else if (idx == `APMUX_IDX_CLK) begin
      if (alt.serial0_clock_en) begin
        f = apmux_pkg::APMUX_FN_S0_CLK;
      end else if (!sel_addr && alt.simple_serial_port_clk_en) begin
        // address keeps the pin over the simple port clock
        f = apmux_pkg::APMUX_FN_SSP_CLK;
      end
    end else if (idx == `APMUX_IDX_CAP_A && alt.simple_serial_port_data_en) begin
      f = apmux_pkg::APMUX_FN_SSP_DATA;
    end
    return f;
  endfunction

  // level and enable for a chosen function
  function automatic apmux_pkg::apmux_drive_t drive_of(
    input apmux_pkg::apmux_func_t f,
    input logic addr_bit,
    input logic pdata,
    input logic pdir,
    input apmux_pkg::apmux_alt_t alt
  );
    apmux_pkg::apmux_drive_t d;
    d.out = 1'b0;
    d.oe = 1'b1;
    unique case (f)
      apmux_pkg::APMUX_FN_PORT: begin
        d.out = pdata;
        d.oe = pdir;
      end
      apmux_pkg::APMUX_FN_ADDR: begin
        d.out = addr_bit;
      end
      apmux_pkg::APMUX_FN_S0_TX: begin
        d.out = alt.serial0_tx_data;
      end
      apmux_pkg::APMUX_FN_S0_CLK: begin
        d.out = alt.serial0_clock_pin;
      end
      apmux_pkg::APMUX_FN_SSP_CLK: begin
        d.out = alt.simple_serial_port_clk;
      end
      apmux_pkg::APMUX_FN_SSP_DATA: begin
        d.out = alt.simple_serial_port_data;
      end
      default: begin
        // unused codes release the pin
        d.oe = 1'b0;
      end
    endcase
    return d;
  endfunction

  // ==========================================================
  // pin input synchroniser
  // pins arrive from outside the clock domain, so every input
  // function sees the pin two flops late
  apmux_sync #(
    .W(`APMUX_UPPER_W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(upper_pin_in),
    .sync_out(pin_sync)
  );

  // ==========================================================
  // next state
  always_comb begin
    apmux_pkg::apmux_drive_t d;
    d = '0;
    state_next = state_reg;
    state_next.low_addr = addr_in[`APMUX_LOW_W-1:0];
    for (int unsigned i = 0; i < `APMUX_UPPER_W; i++) begin
      state_next.func[i] = pick_func(i, upper_sel[i] == `APMUX_SEL_ADDR, alt_in);
      d = drive_of(state_next.func[i], addr_in[`APMUX_UPPER_BASE + i],
                   port4_data[i], port4_dir[i], alt_in);
      state_next.pin_out[i] = d.out;
      state_next.pin_oe[i] = d.oe;
    end
  end

  // ==========================================================
  // state register
  // reset releases every upper pin so nothing fights the board
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg.low_addr <= '0;
      state_reg.pin_out <= `APMUX_RST_OUT;
      state_reg.pin_oe <= `APMUX_RST_OE;
      state_reg.func <= '{default: apmux_pkg::APMUX_FN_PORT};
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs
  assign low_addr_pins = state_reg.low_addr;
  assign upper_pin_out = state_reg.pin_out;
  assign upper_pin_oe = state_reg.pin_oe;
  // port reads see the pin level whatever drives it
  assign port4_read = pin_sync;

  // inputs are tapped regardless of the output function; nothing
  // turns an enabled output driver off while software uses them
  assign periph_out.serial0_rx_data = pin_sync[`APMUX_IDX_RX];
  assign periph_out.capture_in_a = pin_sync[`APMUX_IDX_CAP_A];
  assign periph_out.capture_in_b = pin_sync[`APMUX_IDX_CAP_B];
  assign periph_out.capture_in_c = pin_sync[`APMUX_IDX_CAP_C];
  assign periph_out.timer_in_a = pin_sync[`APMUX_IDX_CAP_A];
  assign periph_out.timer_in_b = pin_sync[`APMUX_IDX_CAP_B];

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic past_ok;
  logic past_ok2;
  logic [1:0] rst_cnt;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_cnt <= 2'h0;
    end else if (rst_cnt != 2'h3) begin
      rst_cnt <= rst_cnt + 2'h1;
    end
  end
  assign past_ok = rst_cnt != 2'h0;
  assign past_ok2 = rst_cnt == 2'h3;

  low_addr_fixed_a: assert property (
    past_ok |-> low_addr_pins == $past(addr_in[`APMUX_LOW_W-1:0]))
    else $error("low address pins do not follow the address");

  upper_addr_drive_a: assert property (
    past_ok && $past(upper_sel[6]) |->
      upper_pin_oe[6] && upper_pin_out[6] == $past(addr_in[22]))
    else $error("upper pin 22 not driving its address bit");

  upper_port_drive_a: assert property (
    past_ok && !$past(upper_sel[1]) |->
      upper_pin_oe[1] == $past(port4_dir[1]) &&
      upper_pin_out[1] == $past(port4_data[1]))
    else $error("upper pin 17 in port mode not following port registers");

  tx_takes_pin_a: assert property (
    past_ok && $past(alt_in.serial0_tx_en) |->
      upper_pin_oe[3] && upper_pin_out[3] == $past(alt_in.serial0_tx_data))
    else $error("serial transmit data not on pin 19");

  tx_off_addr_a: assert property (
    past_ok && !$past(alt_in.serial0_tx_en) && $past(upper_sel[3]) |->
      upper_pin_oe[3] && upper_pin_out[3] == $past(addr_in[19]))
    else $error("pin 19 not on address with transmit disabled");

  clk_pin_port_a: assert property (
    past_ok && !$past(upper_sel[4]) && !$past(alt_in.serial0_clock_en) &&
      $past(alt_in.simple_serial_port_clk_en) |->
      upper_pin_oe[4] && upper_pin_out[4] == $past(alt_in.simple_serial_port_clk))
    else $error("pin 20 used as port while simple clock enabled");

  clk_override_a: assert property (
    past_ok && $past(alt_in.serial0_clock_en) |->
      upper_pin_oe[4] && upper_pin_out[4] == $past(alt_in.serial0_clock_pin))
    else $error("serial clock not on pin 20");

  ssp_data_pin_a: assert property (
    past_ok && $past(alt_in.simple_serial_port_data_en) |->
      upper_pin_oe[5] && upper_pin_out[5] == $past(alt_in.simple_serial_port_data))
    else $error("simple serial data not on pin 21");

  capture_tap_a: assert property (
    past_ok2 |-> periph_out.capture_in_c == $past(upper_pin_in[7], 2) &&
      periph_out.capture_in_a == $past(upper_pin_in[5], 2))
    else $error("capture inputs do not follow their pins");

  timer_tap_a: assert property (
    past_ok2 |-> periph_out.timer_in_b == $past(upper_pin_in[6], 2) &&
      periph_out.timer_in_a == $past(upper_pin_in[5], 2))
    else $error("timer inputs do not follow their pins");

  rx_tap_a: assert property (
    past_ok2 |-> periph_out.serial0_rx_data == $past(upper_pin_in[2], 2))
    else $error("serial receive data does not follow pin 18");

  port_only_a: assert property (
    past_ok && !$past(upper_sel[5]) && !$past(alt_in.simple_serial_port_data_en) |->
      upper_pin_oe[5] == $past(port4_dir[5]) &&
      upper_pin_out[5] == $past(port4_data[5]))
    else $error("alternate function drives pin 21 in port mode");

  // further functions of the shared and plain upper pins
  plain_addr_pin_a: assert property (
    past_ok && $past(upper_sel[7]) |->
      upper_pin_oe[7] && upper_pin_out[7] == $past(addr_in[23]))
    else $error("upper pin 23 not driving its address bit");

  rx_pin_port_a: assert property (
    past_ok && !$past(upper_sel[2]) |->
      upper_pin_oe[2] == $past(port4_dir[2]) &&
      upper_pin_out[2] == $past(port4_data[2]))
    else $error("pin 18 in port mode not following port registers");

  tx_off_port_a: assert property (
    past_ok && !$past(alt_in.serial0_tx_en) && !$past(upper_sel[3]) |->
      upper_pin_oe[3] == $past(port4_dir[3]) &&
      upper_pin_out[3] == $past(port4_data[3]))
    else $error("pin 19 not on port with transmit disabled");

  clk_pin_addr_a: assert property (
    past_ok && $past(upper_sel[4]) && !$past(alt_in.serial0_clock_en) |->
      upper_pin_oe[4] && upper_pin_out[4] == $past(addr_in[20]))
    else $error("pin 20 not on address with serial clock disabled");

  clk_both_off_a: assert property (
    past_ok && !$past(upper_sel[4]) && !$past(alt_in.serial0_clock_en) &&
      !$past(alt_in.simple_serial_port_clk_en) |->
      upper_pin_oe[4] == $past(port4_dir[4]) &&
      upper_pin_out[4] == $past(port4_data[4]))
    else $error("pin 20 not on port with both clocks disabled");

  ssp_off_addr_a: assert property (
    past_ok && !$past(alt_in.simple_serial_port_data_en) && $past(upper_sel[5]) |->
      upper_pin_oe[5] && upper_pin_out[5] == $past(addr_in[21]))
    else $error("pin 21 not on address with simple data disabled");

  pin22_port_a: assert property (
    past_ok && !$past(upper_sel[6]) |->
      upper_pin_oe[6] == $past(port4_dir[6]) &&
      upper_pin_out[6] == $past(port4_data[6]))
    else $error("pin 22 in port mode not following port registers");

  port_read_tap_a: assert property (
    past_ok2 |-> port4_read == $past(upper_pin_in, 2))
    else $error("port reads do not follow the pins");

  reset_release_a: assert property (
    !past_ok |-> upper_pin_oe == 8'h00 && low_addr_pins == 16'h0000)
    else $error("pins driven in the first cycle after reset");

  tx_cover_c: cover property (past_ok && $past(alt_in.serial0_tx_en));
  clk_cover_c: cover property (past_ok && $past(alt_in.serial0_clock_en) &&
    !$past(upper_sel[4]));
  port_cover_c: cover property (past_ok && upper_pin_oe == 8'h00 && rst_n);
  ssp_cover_c: cover property (state_reg.func[4] == apmux_pkg::APMUX_FN_SSP_CLK);
  addr_cover_c: cover property (past_ok && $past(upper_sel[4]) &&
    $past(alt_in.simple_serial_port_clk_en) && !$past(alt_in.serial0_clock_en));

endmodule

// ===== apmux_pin_partner.sv
`timescale 1ns/1ns

// ==========================================================
// far side of the upper pins: resolves each line from both drivers
module apmux_pin_partner (
  input wire logic clk,
  input wire logic [7:0] upper_pin_out,
  input wire logic [7:0] upper_pin_oe,
  input wire logic [7:0] ext_drive,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_level
);
  logic [7:0] float_reg;

  // a floating line toggles so the taps never see a stale level as data
  initial float_reg = 8'h55;
  always @(posedge clk) float_reg <= ~float_reg;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (upper_pin_oe[i]) begin
        pin_level[i] = upper_pin_out[i];
      end else if (ext_en[i]) begin
        pin_level[i] = ext_drive[i];
      end else begin
        pin_level[i] = float_reg[i];
      end
    end
  end
endmodule

// ===== apmux_pkg.sv
package apmux_pkg;

  // what drives one upper pin
  typedef enum logic [2:0] {
    APMUX_FN_PORT = 3'h0,
    APMUX_FN_ADDR = 3'h1,
    APMUX_FN_S0_TX = 3'h2,
    APMUX_FN_S0_CLK = 3'h3,
    APMUX_FN_SSP_CLK = 3'h4,
    APMUX_FN_SSP_DATA = 3'h5
  } apmux_func_t;

  // alternate output functions and their enables
  typedef struct packed {
    logic serial0_tx_en;
    logic serial0_tx_data;
    logic serial0_clock_en;
    logic serial0_clock_pin;
    logic simple_serial_port_clk_en;
    logic simple_serial_port_clk;
    logic simple_serial_port_data_en;
    logic simple_serial_port_data;
  } apmux_alt_t;

  // inputs handed to the peripherals
  typedef struct packed {
    logic serial0_rx_data;
    logic capture_in_a;
    logic capture_in_b;
    logic capture_in_c;
    logic timer_in_a;
    logic timer_in_b;
  } apmux_periph_t;

  // one upper pin: level, enable
  typedef struct packed {
    logic out;
    logic oe;
  } apmux_drive_t;

endpackage

// ===== apmux_sync.sv
`timescale 1ns/1ns

module apmux_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } apmux_sync_state_t;

  apmux_sync_state_t state_reg;
  apmux_sync_state_t state_next;

  // ==========================================================
  // two flops; stage1 is read only by stage2
  always_comb begin
    state_next.stage1 = async_in;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stage2;

endmodule

// ===== tb_address_port_pin_mux.sv
`timescale 1ns/1ns

module tb_address_port_pin_mux;
  logic clk;
  logic rst_n;
  logic [23:0] addr_in;
  logic [7:0] upper_sel, port4_data, port4_dir, ext_drive, ext_en;
  apmux_pkg::apmux_alt_t alt_in;
  logic [15:0] low_addr_pins;
  logic [7:0] pin_level, upper_pin_out, upper_pin_oe, port4_read;
  apmux_pkg::apmux_periph_t periph_out;
  logic [31:0] seed;
  int fail_count, samples_checked;
  logic [7:0] corner_alt [5];
  logic [7:0] corner_sel [5];

  apmux_pin_mux i_apmux_pin_mux (.clk(clk), .rst_n(rst_n), .addr_in(addr_in),
    .upper_sel(upper_sel), .port4_data(port4_data), .port4_dir(port4_dir),
    .alt_in(alt_in), .low_addr_pins(low_addr_pins), .upper_pin_in(pin_level),
    .upper_pin_out(upper_pin_out), .upper_pin_oe(upper_pin_oe),
    .port4_read(port4_read), .periph_out(periph_out));

  apmux_pin_partner i_apmux_pin_partner (.clk(clk), .upper_pin_out(upper_pin_out),
    .upper_pin_oe(upper_pin_oe), .ext_drive(ext_drive), .ext_en(ext_en),
    .pin_level(pin_level));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [1:0] exp_pin(int i, logic a, logic s, logic d, logic r,
                                         apmux_pkg::apmux_alt_t al);
    logic [1:0] e;
    e = s ? {a, 1'b1} : {d, r};
    if (i == 3 && al.serial0_tx_en) e = {al.serial0_tx_data, 1'b1};
    if (i == 4 && al.serial0_clock_en) e = {al.serial0_clock_pin, 1'b1};
    else if (i == 4 && !s && al.simple_serial_port_clk_en) e = {al.simple_serial_port_clk, 1'b1};
    if (i == 5 && al.simple_serial_port_data_en) e = {al.simple_serial_port_data, 1'b1};
    return e;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // stimulus steps
  task automatic apply(input logic [7:0] sel, input logic [7:0] al);
    logic [31:0] r;
    logic [1:0] e;
    r = rnd();
    @(posedge clk);
    addr_in <= r[23:0];
    upper_sel <= sel;
    port4_data <= r[31:24];
    port4_dir <= r[15:8] ^ r[31:24];
    alt_in <= apmux_pkg::apmux_alt_t'(al);
    ext_en <= 8'h00;
    @(posedge clk);
    #1;
    check(low_addr_pins, addr_in[15:0]);
    for (int i = 0; i < 8; i++) begin
      e = exp_pin(i, addr_in[16 + i], upper_sel[i], port4_data[i], port4_dir[i], alt_in);
      check(16'({upper_pin_out[i], upper_pin_oe[i]}), 16'(e));
    end
  endtask

  // pins released by the mux, far side drives them; alt holds the mux-side override on pin 21
  task automatic tap(input logic [7:0] al, input logic [7:0] en);
    logic [7:0] v;
    v = 8'(rnd());
    @(posedge clk);
    upper_sel <= 8'h00;
    port4_dir <= 8'h00;
    alt_in <= apmux_pkg::apmux_alt_t'(al);
    ext_en <= en;
    ext_drive <= v;
    repeat (6) @(posedge clk);
    #1;
    if (en == 8'hFF) check(16'(port4_read), 16'(v));
    if (en == 8'hFF) check(16'(periph_out), 16'({v[2], v[5], v[6], v[7], v[5], v[6]}));
    else check(16'({periph_out.capture_in_a, periph_out.timer_in_a}), 16'({2{al[0]}}));
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    addr_in <= 24'hFFFFFF;
    alt_in <= apmux_pkg::apmux_alt_t'(8'hFF);
    repeat (4) @(posedge clk);
    #1;
    check(low_addr_pins, 16'h0000);
    check(16'({upper_pin_out, upper_pin_oe}), 16'h0000);
    @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    addr_in = 24'h000000;
    {upper_sel, port4_data, port4_dir, ext_drive, ext_en} = 40'h0000000000;
    alt_in = apmux_pkg::apmux_alt_t'(8'h00);
    fail_count = 0;
    samples_checked = 0;
    seed = 32'hD46C;
    corner_alt = '{8'h0C, 8'h0C, 8'h3C, 8'hC3, 8'hFF};
    corner_sel = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF};
    do_reset();
    for (int k = 0; k < 5; k++) apply(corner_sel[k], corner_alt[k]);
    repeat (300) apply(8'(rnd()), 8'(rnd()));
    repeat (40) tap(8'h00, 8'hFF);
    tap(8'h03, 8'h00);
    tap(8'h02, 8'h00);
    do_reset();
    repeat (50) apply(8'(rnd()), 8'(rnd()));
    test_done();
  end
endmodule
